// ==== rtl/odl_consts.svh ====
/*
  Constants for the octal DAC serial load control block: word layout, channel count, reset code, sleep address and mode settle count.
  Assumes it is included by its bare name from the block's design files.
*/
`ifndef ODL_CONSTS_SVH
`define ODL_CONSTS_SVH

`define ODL_WORD_BITS 24
`define ODL_ADDR_MSB 23
`define ODL_ADDR_LSB 16
`define ODL_DATA_MSB 15
`define ODL_DATA_LSB 0
`define ODL_CHANNELS 8
`define ODL_CODE_RESET 16'h0000
`define ODL_ADDR_SLEEP 8'hFF
// Core edges after reset before the load pin shows through its synchroniser
`define ODL_MODE_SETTLE 2'h2

`endif

// ==== rtl/odl_pkg.sv ====
/*
  Types shared by the octal DAC serial load control block.
  Assumes the constants header is included before this package is compiled.
*/
`include "odl_consts.svh"
package odl_pkg;
  // Completed serial word handed from the link domain to the core domain
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] code;
  } odl_word_t;

  // Serial data out pin: value and enable
  typedef struct packed {
    logic out;
    logic oe;
  } odl_pin_t;

  typedef enum logic [2:0] {
    ODL_UPD_IDLE = 3'b001,
    ODL_UPD_SYNC = 3'b010,
    ODL_UPD_ASYNC = 3'b100
  } odl_upd_t;
endpackage

// ==== rtl/odl_sync2.sv ====
/*
  Two flip-flop level synchroniser.
  Assumes the input is a level that changes slowly compared to the clock.
*/
`timescale 1ns/1ps
module odl_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  input wire logic [W-1:0] init_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= init_i;
      q_r <= init_i;
    end else begin
      meta_r <= d_i;
      q_r <= meta_r;
    end
  end

  assign q_o = q_r;
endmodule

// ==== rtl/odl_shift.sv ====
/*
  Serial shift engine on the serial clock: samples input on falling edges,
  launches output on rising edges, and toggles a flag when a whole word ends.
  Assumes the serial clock only runs while chip select is low.
*/
`timescale 1ns/1ps
`include "odl_consts.svh"
module odl_shift #(
  parameter int BITS = `ODL_WORD_BITS
) (
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  input wire logic [BITS-1:0] rd_word_i,
  output logic [BITS-1:0] word_o,
  output logic word_tgl_o,
  output logic sdo_o
);
  logic [BITS-1:0] sh_r;
  logic [5:0] cnt_r;
  logic [BITS-1:0] out_r;
  logic sdo_r;
  logic [BITS-1:0] word_r;
  // Link side has no reset; the word flag starts low and only ever toggles
  logic tgl_r = 1'b0;

  // ************
  // Input shifter
  // ************
  // sample on falling edge
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      cnt_r <= 6'h00;
    end else begin
      sh_r <= {sh_r[BITS-2:0], sdi_i};
      if (cnt_r == 6'(BITS - 1)) begin
        cnt_r <= 6'h00;
        word_r <= {sh_r[BITS-2:0], sdi_i};
        tgl_r <= ~tgl_r;
      end else begin
        cnt_r <= cnt_r + 6'h01;
      end
    end
  end

  // ************
  // Output shifter
  // ************
  // launch on rising edge
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      out_r <= '0;
      sdo_r <= 1'b0;
    end else if (cnt_r == 6'h00) begin
      sdo_r <= rd_word_i[BITS-1];
      out_r <= {rd_word_i[BITS-2:0], 1'b0};
    end else begin
      sdo_r <= out_r[BITS-1];
      out_r <= {out_r[BITS-2:0], 1'b0};
    end
  end

  assign word_o = word_r;
  assign word_tgl_o = tgl_r;
  assign sdo_o = sdo_r;
endmodule

// ==== rtl/odl_top.sv ====
/*
  Serial host interface and output-update control of an eight-channel 16-bit DAC.
  Assumes a host SPI master on the link pins and a free running core clock.
*/
`timescale 1ns/1ps
`include "odl_consts.svh"

// Notes on behaviour
// - Input bits ignored unless chip select low
// - Deselected: output off, clock and data blocked
// - Disable bit clear: output driven when selected
// - Disable bit set: output always off
// - Latch load low: latches transparent
// - Output changes with latch update
// - Wake pulse ends sleep
// - Asynchronous: latch reloads after each register update made with corr_on_i low
// - Load edge after chip select rises
// - Input sampled on clock falling edge
// - Output launched on clock rising edge
// - Sleeping chain passes input straight out
module odl_top #(
  parameter int CH = `ODL_CHANNELS
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  input wire logic latch_load_strobe_n_i,
  input wire logic sleep_exit_n_i,
  input wire logic serial_out_disable_bit_i,
  input wire logic daisy_en_i,
  input wire logic corr_on_i,
  output logic [CH*16-1:0] dac_out_o,
  output logic sleep_o,
  output logic async_mode_o
);
  odl_pkg::odl_word_t word_w;
  odl_pkg::odl_word_t word_r;
  odl_pkg::odl_pin_t pin;
  odl_pkg::odl_upd_t upd_r;
  logic [23:0] word_raw;
  logic [23:0] rd_word;
  logic word_tgl;
  logic sdo_sh;
  logic [2:0] s_in;
  logic [2:0] s_q;
  logic [1:0] settle_r;
  logic tgl_meta_r;
  logic tgl_q_r;
  logic tgl_seen_r;
  logic pending_r;
  logic ld_q_r;
  logic sleep_r;
  logic upd_pulse;
  logic [15:0] data_reg_r [CH];
  logic [15:0] latch_r [CH];
  logic [CH-1:0] reload_r;

  // Selects a channel from the three low address bits
  function automatic logic [2:0] odl_chan(input logic [7:0] a);
    odl_chan = a[2:0];
  endfunction

  // ************
  // Link shifter
  // ************
  // clock blocked when deselected
  odl_shift u_shift (
    .sclk_i(sclk_i & ~cs_n_i),
    .cs_n_i(cs_n_i),
    .sdi_i(sdi_i),
    .rd_word_i(rd_word),
    .word_o(word_raw),
    .word_tgl_o(word_tgl),
    .sdo_o(sdo_sh)
  );
  assign word_w = odl_pkg::odl_word_t'(word_raw);
  assign rd_word = {word_r.addr, data_reg_r[odl_chan(word_r.addr)]};

  // ************
  // Pin synchronisers
  // ************
  assign s_in = {cs_n_i, latch_load_strobe_n_i, sleep_exit_n_i};
  odl_sync2 #(.W(3)) u_sync (
    .clk_i(core_clk_i),
    .rst_i(rst_i),
    .d_i(s_in),
    .init_i(3'h7),
    .q_o(s_q)
  );

  // Word flag crossing; no reset, so it tracks the unreset link flag
  always_ff @(posedge core_clk_i) begin
    tgl_meta_r <= word_tgl;
    tgl_q_r <= tgl_meta_r;
    tgl_seen_r <= tgl_q_r;
  end

  // Word capture; the word itself is stable until the next word ends
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pending_r <= 1'b0;
      word_r <= '0;
    end else begin
      if (tgl_q_r != tgl_seen_r) begin
        pending_r <= 1'b1;
        word_r <= word_w;
      end else if (upd_pulse) begin
        pending_r <= 1'b0;
      end
    end
  end

  // commit while select seen high; the flag lands after the select edge
  assign upd_pulse = pending_r & s_q[2];

  // ************
  // Update mode
  // ************
  // wait until the synchroniser shows the pin, not its reset value
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      settle_r <= 2'h0;
    end else if (settle_r != `ODL_MODE_SETTLE) begin
      settle_r <= settle_r + 2'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      upd_r <= odl_pkg::ODL_UPD_IDLE;
    end else begin
      unique case (upd_r)
        odl_pkg::ODL_UPD_IDLE: begin
          if (settle_r == `ODL_MODE_SETTLE) begin
            upd_r <= s_q[1] ? odl_pkg::ODL_UPD_SYNC : odl_pkg::ODL_UPD_ASYNC;
          end
        end
        odl_pkg::ODL_UPD_SYNC: begin
          upd_r <= odl_pkg::ODL_UPD_SYNC;
        end
        odl_pkg::ODL_UPD_ASYNC: begin
          upd_r <= odl_pkg::ODL_UPD_ASYNC;
        end
        default: begin
          upd_r <= odl_pkg::ODL_UPD_IDLE;
        end
      endcase
    end
  end
  assign async_mode_o = (upd_r == odl_pkg::ODL_UPD_ASYNC);

  // ************
  // Sleep control
  // ************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sleep_r <= 1'b0;
    end else if (!s_q[0]) begin
      sleep_r <= 1'b0;
    end else if (upd_pulse && daisy_en_i && word_r.addr == `ODL_ADDR_SLEEP) begin
      sleep_r <= 1'b1;
    end
  end
  assign sleep_o = sleep_r;

  // ************
  // Data registers and latches
  // ************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ld_q_r <= 1'b1;
      reload_r <= '0;
      for (int i = 0; i < CH; i++) begin
        data_reg_r[i] <= `ODL_CODE_RESET;
        latch_r[i] <= `ODL_CODE_RESET;
      end
    end else begin
      ld_q_r <= s_q[1];
      for (int i = 0; i < CH; i++) begin
        reload_r[i] <= 1'b0;
        if (upd_pulse && word_r.addr != `ODL_ADDR_SLEEP
            && odl_chan(word_r.addr) == 3'(i)) begin
          data_reg_r[i] <= word_r.code;
          reload_r[i] <= ~corr_on_i & ~s_q[1];
        end
        // load edge after chip select rise takes stored data
        if (!s_q[1] || reload_r[i]) begin
          latch_r[i] <= data_reg_r[i];
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < CH; i++) begin
      dac_out_o[i*16 +: 16] = latch_r[i];
    end
  end

  // ************
  // Serial data out
  // ************
  always_comb begin
    pin.out = sleep_r ? sdi_i : sdo_sh;
    pin.oe = ~cs_n_i & ~serial_out_disable_bit_i;
  end
  assign sdo_o = pin.out;
  assign sdo_oe_o = pin.oe;

  // ************
  // Checks
  // ************
  a_sdo_disable_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
    serial_out_disable_bit_i |-> !sdo_oe_o) else $error("sdo driven while disabled");
  a_sdo_desel_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cs_n_i |-> !sdo_oe_o) else $error("sdo driven while deselected");
  a_sdo_enabled_on: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (!cs_n_i && !serial_out_disable_bit_i) |-> sdo_oe_o) else $error("sdo not driven");
  a_sleep_bypass: assert property (@(posedge core_clk_i) disable iff (rst_i)
    sleep_r |-> sdo_o == sdi_i) else $error("sleep bypass broken");
  a_wake_exit: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !s_q[0] |=> !sleep_r) else $error("wake did not end sleep");
  a_mode_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    upd_r != odl_pkg::ODL_UPD_IDLE |=> $stable(upd_r)) else $error("mode changed");
  sequence s_commit;
    upd_pulse && !corr_on_i && !s_q[1] && word_r.addr != `ODL_ADDR_SLEEP;
  endsequence
  a_async_reload: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_commit |-> ##2 latch_r[odl_chan($past(word_r.addr, 2))] == $past(word_r.code, 2))
    else $error("latch not reloaded");
  a_transparent: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (!s_q[1] && $past(!s_q[1])) |-> latch_r[3] == $past(data_reg_r[3]))
    else $error("latch not transparent");
  a_out_follow: assert property (@(posedge core_clk_i) disable iff (rst_i)
    dac_out_o[63:48] == latch_r[3]) else $error("output not following latch");
  a_sync_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ($past(s_q[1]) && !$past(reload_r[1])) |-> $stable(latch_r[1]))
    else $error("latch moved while load high");
  a_load_edge: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ld_q_r && !s_q[1]) |=> latch_r[1] == $past(data_reg_r[1]))
    else $error("load edge did not update latch");
  a_reload_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !upd_pulse |=> reload_r == '0) else $error("reload without register update");

  // ************
  // Word commit checks
  // ************
  // A whole word has crossed from the link side
  sequence s_word_seen;
    tgl_q_r != tgl_seen_r;
  endsequence
  a_word_pending: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_word_seen |=> pending_r && word_r == $past(word_w))
    else $error("word not captured");
  a_commit_once: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (upd_pulse && tgl_q_r == tgl_seen_r) |=> !pending_r)
    else $error("word committed twice");
  a_commit_cs: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (upd_pulse && word_r.addr != `ODL_ADDR_SLEEP)
    |=> data_reg_r[odl_chan($past(word_r.addr))] == $past(word_r.code))
    else $error("word not stored");
  a_sleep_no_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (upd_pulse && word_r.addr == `ODL_ADDR_SLEEP) |=> $stable(data_reg_r[7]))
    else $error("sleep command wrote a register");

  // ************
  // Sleep and mode checks
  // ************
  // Sleep command accepted at commit
  sequence s_sleep_cmd;
    upd_pulse && daisy_en_i && word_r.addr == `ODL_ADDR_SLEEP;
  endsequence
  a_sleep_enter: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_sleep_cmd |=> sleep_r || !$past(s_q[0])) else $error("sleep not entered");
  a_sleep_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (sleep_r && s_q[0]) |=> sleep_r) else $error("sleep left without wake");
  a_sleep_plain: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (!sleep_r && !daisy_en_i) |=> !sleep_r) else $error("sleep outside chain mode");
  a_shift_path: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !sleep_r |-> sdo_o == sdo_sh) else $error("shift output not on pin");
  a_desel_quiet: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cs_n_i |-> !sdo_sh) else $error("shift output active while deselected");
  a_upd_onehot: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $onehot(upd_r)) else $error("update mode code illegal");
  a_mode_caught: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (upd_r == odl_pkg::ODL_UPD_IDLE && settle_r == `ODL_MODE_SETTLE)
    |=> async_mode_o == !$past(s_q[1])) else $error("update mode not caught");
endmodule

// ==== sim/odl_host.sv ====
/*
  Host master model for the serial link of the octal DAC load control block.
  Assumes the bench calls its tasks; serial clock period is 48 ns, idle low.
*/
`timescale 1ns/1ps
module odl_host (
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end

  // bit set up early: data changes three quarters of a period (36 ns) before the falling edge
  task automatic send(input logic [23:0] w, input int n, output logic [23:0] rd);
    rd = 24'h000000;
    cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      #12 sdi_o = w[23-i];
      #12 sclk_o = 1'b1;
      #24 rd = {rd[22:0], sdo_i};
      sclk_o = 1'b0;
    end
    #12 cs_n_o = 1'b1;
    // Released data line shows the inverse of its last value
    sdi_o = ~sdi_o;
  endtask

  // Clock and data toggling while deselected
  task automatic noise();
    for (int i = 0; i < 8; i++) begin
      #24 sclk_o = 1'b1;
      sdi_o = ~sdi_o;
      #24 sclk_o = 1'b0;
    end
  endtask

  task automatic select(input logic v);
    cs_n_o = v;
  endtask

  task automatic drive(input logic v);
    sdi_o = v;
  endtask
endmodule

// ==== sim/testbench.sv ====
/*
  Self-checking bench for the octal DAC serial load control block.
  Assumes the host model file is compiled first.
*/
`timescale 1ns/1ps
module testbench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ld_n = 1'b0;
  logic wake_n = 1'b1;
  logic dis = 1'b0;
  logic daisy = 1'b0;
  logic sclk, cs_n, sdi, sdo, sdo_oe, sleep, amode;
  logic [127:0] dac;
  logic [23:0] rd;
  int error_cnt = 0;
  int comparisons = 0;

  always #50 core_clk = ~core_clk;

  // Pin not driven: the host sees the opposite level
  odl_host host (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo_oe ? sdo : ~sdo));
  odl_top dut (.core_clk_i(core_clk), .rst_i(rst), .sclk_i(sclk), .cs_n_i(cs_n),
    .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .latch_load_strobe_n_i(ld_n),
    .sleep_exit_n_i(wake_n), .serial_out_disable_bit_i(dis), .daisy_en_i(daisy),
    .corr_on_i(1'b0), .dac_out_o(dac), .sleep_o(sleep), .async_mode_o(amode));

  task automatic wcyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask

  task automatic do_rst(input logic ld);
    @(posedge core_clk);
    rst <= 1'b1;
    ld_n <= ld;
    wcyc(10);
    rst <= 1'b0;
    wcyc(6);
  endtask

  task automatic t_write();
    chk("async mode", 24'h1, {23'h0, amode});
    host.send(24'h03A5C3, 24, rd);
    wcyc(10);
    chk("ch3 code", 24'hA5C3, {8'h0, dac[48+:16]});
    host.send(24'h031234, 24, rd);
    chk("readback", 24'h03A5C3, rd);
    wcyc(10);
    chk("ch3 second", 24'h1234, {8'h0, dac[48+:16]});
    $display("test write done");
  endtask

  task automatic t_refuse();
    host.send(24'h05FFFF, 10, rd);
    wcyc(10);
    chk("partial", 24'h0, {8'h0, dac[80+:16]});
    host.noise();
    host.send(24'h0500AA, 24, rd);
    wcyc(10);
    chk("after noise", 24'h00AA, {8'h0, dac[80+:16]});
    $display("test refuse done");
  endtask

  task automatic t_oe();
    chk("oe idle", 24'h0, {23'h0, sdo_oe});
    host.select(1'b0);
    wcyc(2);
    chk("oe selected", 24'h1, {23'h0, sdo_oe});
    dis <= 1'b1;
    wcyc(2);
    chk("oe disabled", 24'h0, {23'h0, sdo_oe});
    host.select(1'b1);
    wcyc(2);
    chk("oe off deselected", 24'h0, {23'h0, sdo_oe});
    dis <= 1'b0;
    $display("test output enable done");
  endtask

  task automatic t_sleep();
    daisy <= 1'b1;
    host.send(24'hFF0000, 24, rd);
    wcyc(10);
    chk("sleep on", 24'h1, {23'h0, sleep});
    host.drive(1'b1);
    #5 chk("pass high", 24'h1, {23'h0, sdo});
    host.drive(1'b0);
    #5 chk("pass low", 24'h0, {23'h0, sdo});
    @(posedge core_clk);
    wake_n <= 1'b0;
    wcyc(4);
    wake_n <= 1'b1;
    wcyc(4);
    chk("sleep off", 24'h0, {23'h0, sleep});
    daisy <= 1'b0;
    $display("test sleep done");
  endtask

  task automatic t_sync();
    do_rst(1'b1);
    chk("sync mode", 24'h0, {23'h0, amode});
    host.send(24'h010F0F, 24, rd);
    wcyc(10);
    chk("ch1 held", 24'h0, {8'h0, dac[16+:16]});
    // load edge issued after select rises
    ld_n <= 1'b0;
    wcyc(6);
    ld_n <= 1'b1;
    chk("ch1 loaded", 24'h0F0F, {8'h0, dac[16+:16]});
    $display("test sync done");
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    do_rst(1'b0);
    t_write();
    t_refuse();
    t_oe();
    t_sleep();
    t_sync();
    end_of_test();
  end
endmodule
